// ==== pkg/cefb_defs.vh ====
// Offsets, field positions and reset values of the charger event flags
`ifndef CEFB_DEFS_VH
`define CEFB_DEFS_VH

// Register offsets on the control port
`define CEFB_OFS_FIRST          8'h23
`define CEFB_OFS_SECOND         8'h24
`define CEFB_OFS_THIRD          8'h25

// Power-on value of every flag register
`define CEFB_FLAG_RESET         8'h00

// First flag register fields
`define CEFB_F1_CHG_STATE       7
`define CEFB_F1_ICO             6
`define CEFB_F1_INPUT_BUS       4
`define CEFB_F1_THERMAL_REG     2
`define CEFB_F1_BAT_PRESENT     1
`define CEFB_F1_PORT_DETECT     0

// Second flag register fields
`define CEFB_F2_DLINE_DONE      6
`define CEFB_F2_CONV_DONE       5
`define CEFB_F2_MIN_SYS         4
`define CEFB_F2_FAST_TMR        3
`define CEFB_F2_TRICKLE_TMR     2
`define CEFB_F2_PRECHG_TMR      1
`define CEFB_F2_TOPOFF_TMR      0

// Third flag register fields
`define CEFB_F3_BAT_LOW_BOOST   4
`define CEFB_F3_TS_COLD         3
`define CEFB_F3_TS_COOL         2
`define CEFB_F3_TS_WARM         1
`define CEFB_F3_TS_HOT          0

// Bits that exist; all others are reserved and read zero
`define CEFB_F1_IMPL            8'hD7
`define CEFB_F2_IMPL            8'h7F
`define CEFB_F3_IMPL            8'h1F

// Defaults of the status field widths
`define CEFB_CHG_W              3
`define CEFB_ICO_W              2
`define CEFB_BUS_W              4
`define CEFB_DET_W              4

`endif

// ==== verilog/cefb_flag_bank.v ====
// Charger event flag bank: three read-to-clear event flag registers
//
// Functional notes
// - Three 8-bit flag registers, zero after reset.
// - First reg bit 7 on charge state change.
// - First reg bit 6 on optimizer status change.
// - First reg bit 4 on input bus change.
// - First reg bit 2 on thermal regulation rise.
// - First reg bit 1 on battery presence change.
// - First reg bit 0 on port detection change.
// - Second reg bit 6 once data-line detection done.
// - Second reg bit 5 on one-shot conversion done.
// - Second reg bit 4 entering/leaving minimum system regulation.
// - Second reg bit 3 on fast-charge timeout rise.
// - Second reg bit 2 on trickle timeout rise.
// - Second reg bit 1 on precharge timeout rise.
// - Second reg bit 0 on top-off timeout rise.
// - Third reg bit 4 when battery too low.
// - Third reg bit 3 on cold threshold crossing.
// - Third reg bit 2 on cool threshold crossing.
// - Third reg bit 1 on warm threshold crossing.
// - Third reg bit 0 on hot threshold crossing.
// - Unmasked events pulse the interrupt output.
//
// Every watched condition but CONV_DONE is sampled once per clock and compared with
// the sample taken one edge earlier. Multi-bit codes flag on any change.
// Plain levels flag on a rising edge or on either edge, bit by bit.
// The first edge after reset only fills the history, so a condition
// that is already high when reset lifts does not raise a false event.
//
// A read of a flag register returns its value before the clear and then
// clears the whole register. An event in the read cycle wins over the
// clear, so a read never loses an event of its own cycle. Offsets outside
// the three flag registers read zero and clear nothing.
//
// Masks only hide an event from the interrupt pulse; the flag still
// sets. Several events in one cycle give a single pulse, so software
// must read all three registers after a pulse to find every cause.
//
`timescale 1ns/1ps
`include "cefb_defs.vh"

module cefb_flag_bank #(
    parameter CHG_W = `CEFB_CHG_W,
    parameter ICO_W = `CEFB_ICO_W,
    parameter BUS_W = `CEFB_BUS_W,
    parameter DET_W = `CEFB_DET_W
) (
    input  wire             CORE_CLK,
    input  wire             RSTN,
    // Register read port of the control interface
    input  wire             REG_RD_STB,
    input  wire [7:0]       REG_ADDR,
    output reg  [7:0]       REG_RD_DATA,
    output reg              REG_RD_VALID,
    // Status conditions from the charger core
    input  wire [CHG_W-1:0] CHARGE_STATE,
    input  wire [ICO_W-1:0] ICO_STATE,
    input  wire [BUS_W-1:0] INPUT_BUS_STATE,
    input  wire             THERMAL_REG_ACTIVE,
    input  wire             BAT_PRESENT,
    input  wire [DET_W-1:0] PORT_DETECT_RESULT,
    input  wire             DLINE_DETECT_BUSY,
    input  wire             DLINE_DETECT_DONE,
    input  wire             CONV_DONE,
    input  wire             CONV_ONE_SHOT,
    input  wire             MIN_SYS_REG_ACTIVE,
    input  wire             FAST_TMR_EXPIRED,
    input  wire             TRICKLE_TMR_EXPIRED,
    input  wire             PRECHG_TMR_EXPIRED,
    input  wire             TOPOFF_TMR_EXPIRED,
    input  wire             BAT_LOW_FOR_BOOST,
    input  wire             TS_COLD,
    input  wire             TS_COOL,
    input  wire             TS_WARM,
    input  wire             TS_HOT,
    // Mask bits from the mask registers, one per flag bit
    input  wire [7:0]       MASK_FIRST,
    input  wire [7:0]       MASK_SECOND,
    input  wire [7:0]       MASK_THIRD,
    // Interrupt pulse, high the cycle after any cycle with unmasked events
    output reg              INT_PULSE
);

    // Read strobe aimed at one flag register
    function rd_hit;
        input       stb;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            rd_hit = stb && (addr == ofs);
        end
    endfunction

    // Rising edge of a one-bit condition against its last sample
    function rise;
        input now;
        input last;
        begin
            rise = now & ~last;
        end
    endfunction

    // Either edge of a one-bit condition against its last sample
    function flip;
        input now;
        input last;
        begin
            flip = now ^ last;
        end
    endfunction

    // Flag registers
    reg  [7:0]       flags1_r;
    reg  [7:0]       flags2_r;
    reg  [7:0]       flags3_r;
    reg  [7:0]       flags1_nxt;
    reg  [7:0]       flags2_nxt;
    reg  [7:0]       flags3_nxt;

    // Previous samples of the watched conditions
    reg  [CHG_W-1:0] chg_prev_r;
    reg  [ICO_W-1:0] ico_prev_r;
    reg  [BUS_W-1:0] bus_prev_r;
    reg  [DET_W-1:0] det_prev_r;
    reg              treg_prev_r;
    reg              bat_prev_r;
    reg              dline_prev_r;
    reg              minsys_prev_r;
    reg              fast_prev_r;
    reg              trickle_prev_r;
    reg              prechg_prev_r;
    reg              topoff_prev_r;
    reg              batlow_prev_r;
    reg              cold_prev_r;
    reg              cool_prev_r;
    reg              warm_prev_r;
    reg              hot_prev_r;
    reg              primed_r;

    // Event vectors, one bit per flag position
    reg  [7:0]       evt1;
    reg  [7:0]       evt2;
    reg  [7:0]       evt3;
    reg  [7:0]       clr1;
    reg  [7:0]       clr2;
    reg  [7:0]       clr3;
    // Events that survive their mask and reach the interrupt
    reg  [7:0]       live1;
    reg  [7:0]       live2;
    reg  [7:0]       live3;
    reg  [7:0]       rd_data_nxt;
    wire             hit1;
    wire             hit2;
    wire             hit3;

    assign hit1 = rd_hit(REG_RD_STB, REG_ADDR, `CEFB_OFS_FIRST);
    assign hit2 = rd_hit(REG_RD_STB, REG_ADDR, `CEFB_OFS_SECOND);
    assign hit3 = rd_hit(REG_RD_STB, REG_ADDR, `CEFB_OFS_THIRD);

    // Sample history; the first cycle after reset only primes it,
    // since the reset value of a sample is not a real prior state
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            chg_prev_r     <= {CHG_W{1'b0}};
            ico_prev_r     <= {ICO_W{1'b0}};
            bus_prev_r     <= {BUS_W{1'b0}};
            det_prev_r     <= {DET_W{1'b0}};
            treg_prev_r    <= 1'b0;
            bat_prev_r     <= 1'b0;
            dline_prev_r   <= 1'b0;
            minsys_prev_r  <= 1'b0;
            fast_prev_r    <= 1'b0;
            trickle_prev_r <= 1'b0;
            prechg_prev_r  <= 1'b0;
            topoff_prev_r  <= 1'b0;
            batlow_prev_r  <= 1'b0;
            cold_prev_r    <= 1'b0;
            cool_prev_r    <= 1'b0;
            warm_prev_r    <= 1'b0;
            hot_prev_r     <= 1'b0;
            primed_r       <= 1'b0;
        end else begin
            chg_prev_r     <= CHARGE_STATE;
            ico_prev_r     <= ICO_STATE;
            bus_prev_r     <= INPUT_BUS_STATE;
            det_prev_r     <= PORT_DETECT_RESULT;
            treg_prev_r    <= THERMAL_REG_ACTIVE;
            bat_prev_r     <= BAT_PRESENT;
            dline_prev_r   <= DLINE_DETECT_DONE;
            minsys_prev_r  <= MIN_SYS_REG_ACTIVE;
            fast_prev_r    <= FAST_TMR_EXPIRED;
            trickle_prev_r <= TRICKLE_TMR_EXPIRED;
            prechg_prev_r  <= PRECHG_TMR_EXPIRED;
            topoff_prev_r  <= TOPOFF_TMR_EXPIRED;
            batlow_prev_r  <= BAT_LOW_FOR_BOOST;
            cold_prev_r    <= TS_COLD;
            cool_prev_r    <= TS_COOL;
            warm_prev_r    <= TS_WARM;
            hot_prev_r     <= TS_HOT;
            primed_r       <= 1'b1;
        end
    end

    // Events of the first register
    always @* begin
        evt1 = 8'h00;
        evt1[`CEFB_F1_CHG_STATE] = CHARGE_STATE != chg_prev_r;
        evt1[`CEFB_F1_ICO] = ICO_STATE != ico_prev_r;
        evt1[`CEFB_F1_INPUT_BUS] = INPUT_BUS_STATE != bus_prev_r;
        evt1[`CEFB_F1_THERMAL_REG] =
            rise(THERMAL_REG_ACTIVE, treg_prev_r);
        evt1[`CEFB_F1_BAT_PRESENT] = flip(BAT_PRESENT, bat_prev_r);
        evt1[`CEFB_F1_PORT_DETECT] =
            PORT_DETECT_RESULT != det_prev_r;
        if (!primed_r) begin
            evt1 = 8'h00;
        end
    end

    // Events of the second register
    always @* begin
        evt2 = 8'h00;
        evt2[`CEFB_F2_DLINE_DONE] =
            rise(DLINE_DETECT_DONE, dline_prev_r);
        // Conversions in continuous mode never flag
        evt2[`CEFB_F2_CONV_DONE] = CONV_DONE & CONV_ONE_SHOT;
        evt2[`CEFB_F2_MIN_SYS] =
            flip(MIN_SYS_REG_ACTIVE, minsys_prev_r);
        // Timer expiries flag only when they first appear
        evt2[`CEFB_F2_FAST_TMR] =
            rise(FAST_TMR_EXPIRED, fast_prev_r);
        evt2[`CEFB_F2_TRICKLE_TMR] =
            rise(TRICKLE_TMR_EXPIRED, trickle_prev_r);
        evt2[`CEFB_F2_PRECHG_TMR] =
            rise(PRECHG_TMR_EXPIRED, prechg_prev_r);
        evt2[`CEFB_F2_TOPOFF_TMR] =
            rise(TOPOFF_TMR_EXPIRED, topoff_prev_r);
        if (!primed_r) begin
            evt2 = 8'h00;
        end
    end

    // Events of the third register; thresholds count either direction
    always @* begin
        evt3 = 8'h00;
        // Only the fall below the boost level counts, not the recovery
        evt3[`CEFB_F3_BAT_LOW_BOOST] =
            rise(BAT_LOW_FOR_BOOST, batlow_prev_r);
        evt3[`CEFB_F3_TS_COLD] = flip(TS_COLD, cold_prev_r);
        evt3[`CEFB_F3_TS_COOL] = flip(TS_COOL, cool_prev_r);
        evt3[`CEFB_F3_TS_WARM] = flip(TS_WARM, warm_prev_r);
        evt3[`CEFB_F3_TS_HOT] = flip(TS_HOT, hot_prev_r);
        if (!primed_r) begin
            evt3 = 8'h00;
        end
    end

    // Clear masks: a read clears its whole register
    always @* begin
        clr1 = hit1 ? 8'hFF : 8'h00;
        clr2 = hit2 ? 8'hFF : 8'h00;
        clr3 = hit3 ? 8'hFF : 8'h00;
        // Detection restarting takes the done indication back to 0
        if (DLINE_DETECT_BUSY) begin
            clr2[`CEFB_F2_DLINE_DONE] = 1'b1;
        end
    end

    // Set beats clear so an event landing on a read is not lost
    always @* begin
        flags1_nxt = ((flags1_r & ~clr1) | evt1) & `CEFB_F1_IMPL;
        flags2_nxt = ((flags2_r & ~clr2) | evt2) & `CEFB_F2_IMPL;
        flags3_nxt = ((flags3_r & ~clr3) | evt3) & `CEFB_F3_IMPL;
    end

    // Flag storage, all zero after reset
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flags1_r <= `CEFB_FLAG_RESET;
            flags2_r <= `CEFB_FLAG_RESET;
            flags3_r <= `CEFB_FLAG_RESET;
        end else begin
            flags1_r <= flags1_nxt;
            flags2_r <= flags2_nxt;
            flags3_r <= flags3_nxt;
        end
    end

    // Read data: value before the clear; unmapped offsets read zero
    always @* begin
        rd_data_nxt = 8'h00;
        if (hit1) begin
            rd_data_nxt = flags1_r & `CEFB_F1_IMPL;
        end else if (hit2) begin
            rd_data_nxt = flags2_r & `CEFB_F2_IMPL;
        end else if (hit3) begin
            rd_data_nxt = flags3_r & `CEFB_F3_IMPL;
        end
    end

    // Registered read answer, data held until the next read
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RD_DATA  <= 8'h00;
            REG_RD_VALID <= 1'b0;
        end else begin
            REG_RD_VALID <= REG_RD_STB;
            if (REG_RD_STB) begin
                REG_RD_DATA <= rd_data_nxt;
            end
        end
    end

    // Unmasked events; a set mask bit hides only its own event
    always @* begin
        live1 = evt1 & ~MASK_FIRST;
        live2 = evt2 & ~MASK_SECOND;
        live3 = evt3 & ~MASK_THIRD;
    end

    // Interrupt pulse; back to back events merge into a longer level
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            INT_PULSE <= 1'b0;
        end else begin
            INT_PULSE <= (|live1) | (|live2) | (|live3);
        end
    end

endmodule

// ==== verification/cefb_host.sv ====
// Host model issuing register reads on the control port
`timescale 1ns/1ps
module cefb_host (
    input  wire       CORE_CLK,
    output reg        REG_RD_STB,
    output reg  [7:0] REG_ADDR
);
    initial begin
        REG_RD_STB = 1'b0;
        REG_ADDR   = 8'h00;
    end
    // One strobe per call; calls in a row give back to back reads
    task rd(input [7:0] a);
        @(posedge CORE_CLK);
        REG_RD_STB <= 1'b1;
        REG_ADDR   <= a;
    endtask
    // Release; inverted address so a stale offset never looks valid
    task idle(input integer n);
        @(posedge CORE_CLK);
        REG_RD_STB <= 1'b0;
        REG_ADDR   <= ~REG_ADDR;
        repeat (n) @(posedge CORE_CLK);
    endtask
endmodule

// ==== verification/cefb_flag_bank_properties.sv ====
// Concurrent checks on the charger event flag bank ports
`timescale 1ns/1ps
module cefb_flag_bank_props (
    input wire       CORE_CLK,
    input wire       RSTN,
    input wire       REG_RD_STB,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_RD_DATA,
    input wire       REG_RD_VALID,
    input wire       TS_COLD,
    input wire       TS_HOT,
    input wire [7:0] MASK_FIRST,
    input wire [7:0] MASK_SECOND,
    input wire [7:0] MASK_THIRD,
    input wire       INT_PULSE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    // Read decode; anything else is unmapped
    wire rd1 = REG_RD_STB && REG_ADDR == 8'h23;
    wire rd2 = REG_RD_STB && REG_ADDR == 8'h24;
    wire rd3 = REG_RD_STB && REG_ADDR == 8'h25;
    wire rdx = REG_RD_STB && !rd1 && !rd2 && !rd3;
    wire all_m = &MASK_FIRST && &MASK_SECOND && &MASK_THIRD;

    a_read_answer: assert property (REG_RD_STB |=> REG_RD_VALID)
        else $error("read not answered");
    a_valid_pulse: assert property (!REG_RD_STB |=> !REG_RD_VALID)
        else $error("answer without read");
    a_rsvd_first: assert property (rd1 |=> !(REG_RD_DATA & 8'h28))
        else $error("reserved bit set in first register");
    a_rsvd_second: assert property (rd2 |=> !REG_RD_DATA[7])
        else $error("reserved bit set in second register");
    a_rsvd_third: assert property (rd3 |=> !REG_RD_DATA[7:5])
        else $error("reserved bit set in third register");
    a_unmapped_zero: assert property (rdx |=> REG_RD_DATA == 8'h00)
        else $error("unmapped offset not zero");
    a_hot_int: assert property ($changed(TS_HOT) && !MASK_THIRD[0]
        && $past(RSTN) |=> INT_PULSE) else $error("hot change no pulse");
    a_cold_flag: assert property ($changed(TS_COLD) && $past(RSTN)
        ##1 rd3 |=> REG_RD_DATA[3]) else $error("cold flag not read");
    a_mask_quiet: assert property (all_m |=> !INT_PULSE)
        else $error("pulse while all masked");

    c_int: cover property (INT_PULSE);
    c_flag: cover property (REG_RD_VALID && REG_RD_DATA != 8'h00);
    c_b2b: cover property (REG_RD_STB ##1 REG_RD_STB);
endmodule

bind cefb_flag_bank cefb_flag_bank_props u_props (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_RD_STB(REG_RD_STB),
    .REG_ADDR(REG_ADDR), .REG_RD_DATA(REG_RD_DATA),
    .REG_RD_VALID(REG_RD_VALID), .TS_COLD(TS_COLD), .TS_HOT(TS_HOT),
    .MASK_FIRST(MASK_FIRST), .MASK_SECOND(MASK_SECOND),
    .MASK_THIRD(MASK_THIRD), .INT_PULSE(INT_PULSE));

// ==== verification/testbench.sv ====
// Self-checking bench for the charger event flag bank
`timescale 1ns/1ps
module testbench;
    reg         CORE_CLK = 1'b0;
    reg         RSTN = 1'b0;
    reg  [17:0] tog = 18'h0;
    reg  [12:0] rnd = 13'h0;
    reg         busy = 1'b0;
    reg         one_shot = 1'b0;
    reg  [7:0]  m1 = 8'h00, m2 = 8'h00, m3 = 8'h00;
    reg  [7:0]  a, e, mk;
    reg  [12:0] nr;
    wire        stb, rvalid, intp;
    wire [7:0]  addr, rdata;
    logic [7:0] exp_q [$];
    int         error_cnt = 0, checks = 0, seed, p, k;
    int         bp [18] = '{7,6,4,2,1,0,6,5,4,3,2,1,0,4,3,2,1,0};
    reg  [17:0] both = 18'h3C137; // Kinds flagged on either edge
    reg  [7:0]  ofs [5] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h00};

    cefb_host u_cefb_host (.CORE_CLK(CORE_CLK), .REG_RD_STB(stb),
        .REG_ADDR(addr));
    cefb_flag_bank u_cefb_flag_bank (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
        .REG_RD_STB(stb), .REG_ADDR(addr), .REG_RD_DATA(rdata),
        .REG_RD_VALID(rvalid), .CHARGE_STATE(rnd[2:0] ^ {3{tog[0]}}),
        .ICO_STATE(rnd[4:3] ^ {2{tog[1]}}),
        .INPUT_BUS_STATE(rnd[8:5] ^ {4{tog[2]}}),
        .THERMAL_REG_ACTIVE(tog[3]), .BAT_PRESENT(tog[4]),
        .PORT_DETECT_RESULT(rnd[12:9] ^ {4{tog[5]}}),
        .DLINE_DETECT_BUSY(busy), .DLINE_DETECT_DONE(tog[6]),
        .CONV_DONE(tog[7]), .CONV_ONE_SHOT(one_shot),
        .MIN_SYS_REG_ACTIVE(tog[8]), .FAST_TMR_EXPIRED(tog[9]),
        .TRICKLE_TMR_EXPIRED(tog[10]), .PRECHG_TMR_EXPIRED(tog[11]),
        .TOPOFF_TMR_EXPIRED(tog[12]), .BAT_LOW_FOR_BOOST(tog[13]),
        .TS_COLD(tog[14]), .TS_COOL(tog[15]), .TS_WARM(tog[16]),
        .TS_HOT(tog[17]), .MASK_FIRST(m1), .MASK_SECOND(m2),
        .MASK_THIRD(m3), .INT_PULSE(intp));

    task chk(input string n, input [7:0] s, input [7:0] x);
        checks++;
        if (s !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask

    task complete_run;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Clock, 4 ns period
    initial begin
        forever #2 CORE_CLK = ~CORE_CLK;
    end

    // Watchdog; the full run needs under 2 us
    initial begin
        #20000;
        error_cnt++;
        complete_run;
    end

    // Read answers are matched in order against the noted values
    always @(posedge CORE_CLK)
        if (RSTN && rvalid === 1'b1)
            chk("read data", rdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);

    // Main sequence
    initial begin
        seed = $urandom(32'h09F7B2A7);
        repeat (10) @(posedge CORE_CLK);
        rnd <= 13'($urandom);
        RSTN <= 1'b1;
        foreach (ofs[i]) begin
            exp_q.push_back(8'h00);
            u_cefb_host.rd(ofs[i]);
        end
        u_cefb_host.idle(1);
        // Each kind toggled up then back; single-edge kinds flag once
        for (p = 0; p < 2; p++) begin
            // Fresh status codes; each changed field flags once
            nr = 13'($urandom);
            e = {rnd[2:0] != nr[2:0], rnd[4:3] != nr[4:3], 1'b0,
                rnd[8:5] != nr[8:5], 3'b000, rnd[12:9] != nr[12:9]};
            @(posedge CORE_CLK);
            rnd <= nr;
            @(posedge CORE_CLK);
            exp_q.push_back(e);
            u_cefb_host.rd(8'h23);
            u_cefb_host.idle(1);
            for (k = 0; k < 18; k++) begin
                a = k < 6 ? 8'h23 : k < 13 ? 8'h24 : 8'h25;
                e = (p == 0 || both[k]) ? 8'h01 << bp[k] : 8'h00;
                @(posedge CORE_CLK);
                tog[k] <= (k == 7) ? 1'b1 : ~tog[k];
                one_shot <= (p == 0);
                {m1, m2, m3} <= 24'($urandom);
                @(posedge CORE_CLK);
                if (k == 7)
                    tog[7] <= 1'b0;
                #1;
                mk = a == 8'h23 ? m1 : a == 8'h24 ? m2 : m3;
                chk("interrupt", {7'h00, intp}, {7'h00, |(e & ~mk)});
                exp_q.push_back(e);
                exp_q.push_back(8'h00);
                u_cefb_host.rd(a);
                u_cefb_host.rd(a);
                u_cefb_host.idle($urandom_range(0, 3));
            end
        end
        // Detection restarting clears the done flag, all masked
        @(posedge CORE_CLK);
        tog[6] <= 1'b1;
        {m1, m2, m3} <= 24'hFFFFFF;
        @(posedge CORE_CLK);
        busy <= 1'b1;
        exp_q.push_back(8'h00);
        u_cefb_host.rd(8'h24);
        u_cefb_host.idle(3);
        complete_run;
    end
endmodule
